// ===== src/sifs_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "sifs_map.svh"

// Notes on behaviour
// (RULE_01) second field top bits 11 makes third field ignored
// (RULE_02) zeroth field top bits 11 makes first field ignored
// (RULE_03) code 0001: on with link, blink on activity, dark without link
// (RULE_04) code 0011 on with activity; 0100 blinks with activity
// (RULE_05) third and first, code 0010: on link, blink on receive
// (RULE_06) third, second, zeroth: 1000 off, 1001 on, 1010 hi-z, 1011 blink
// (RULE_07) first: 1000 off, 1001 on, 1010 blink; 11xx reserved
// (RULE_08) third, code 0000: on only with fiber link
// (RULE_09) third, code 0110: on at 10 Mbps or 1000 Mbps master
// (RULE_10) third, code 0111: on full duplex, dark half duplex
// (RULE_11) third: 0101 and 11xx reserved
// (RULE_12) second and zeroth, code 0000: on with link
// (RULE_13) second and zeroth, code 0101: on while transmitting
// (RULE_14) second, code 0110: on at 10 or 1000 Mbps link
// (RULE_15) second, code 0111: on only at 10 Mbps; 0010 reserved
// (RULE_16) second: 1100, 1110, 1111 select dual patterns one, two, four
// (RULE_17) zeroth: 1100, 1110, 1111 select dual patterns one, two, three
// (RULE_18) first, code 0000: on only with copper link
// (RULE_19) first, code 0101: on at 100 Mbps or any fiber link
// (RULE_20) first: 0110 on at 100/1000 Mbps; 0111 only at 100 Mbps
// (RULE_21) zeroth, code 0010: burst of three, two, one or no blinks by speed
// (RULE_22) zeroth: 0110 on with copper link; 0111 only at 1000 Mbps
// (RULE_23) on drives the pin low, off drives it high
// (RULE_24) all blinking follows one shared timer so indicators blink in phase; the zeroth's speed burst keeps its own phase counter, out of step
// (RULE_25) unlisted or reserved code leaves the indicator dark
module sifs_top #(
	parameter int BURST_PHASES = `SIFS_BURST_PHASES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire sifs_pkg::sifs_status_t link_status,
	input wire logic blink_tick,
	output logic indicator_out_0,
	output logic indicator_out_1,
	output logic indicator_out_2,
	output logic indicator_out_3,
	output logic indicator_oe_n_0,
	output logic indicator_oe_n_1,
	output logic indicator_oe_n_2,
	output logic indicator_oe_n_3
);

	// ----------------------------------------
	// checks
	// ----------------------------------------
	if (BURST_PHASES < 7 || BURST_PHASES > 8) begin : g_bad_burst
		$error("sifs_top: BURST_PHASES must be 7 or 8");
	end

	sifs_pkg::sifs_state_t st_ff;
	sifs_pkg::sifs_state_t nxt_st;
	logic burst_lit;
	logic [1:0] burst_count;
	logic [3:0] code3;
	logic [3:0] code2;
	logic [3:0] code1;
	logic [3:0] code0;
	logic pair_hi;
	logic pair_lo;
	sifs_pkg::sifs_drive_t drv [4];

	assign code3 = st_ff.func_sel[`SIFS_F3_LO +: 4];
	assign code2 = st_ff.func_sel[`SIFS_F2_LO +: 4];
	assign code1 = st_ff.func_sel[`SIFS_F1_LO +: 4];
	assign code0 = st_ff.func_sel[`SIFS_F0_LO +: 4];
	assign pair_hi = (code2[3:2] == `SIFS_PAIR_CODE);
	assign pair_lo = (code0[3:2] == `SIFS_PAIR_CODE);

	// ----------------------------------------
	// speed burst for the zeroth indicator
	// ----------------------------------------
	always_comb begin
		burst_count = 2'h0;
		if (link_status.link_up) begin
			case (link_status.speed)
				`SIFS_SPD_1000: burst_count = 2'h3; // [RULE_21]
				`SIFS_SPD_100: burst_count = 2'h2;
				`SIFS_SPD_10: burst_count = 2'h1;
				default: burst_count = 2'h0;
			endcase
		end
	end

	sifs_burst #(
		.PHASES(BURST_PHASES)
	) u_burst (
		.pclk(pclk),
		.presetn(presetn),
		.blink_tick(blink_tick),
		.blink_count(burst_count),
		.burst_lit(burst_lit)
	);

	// ----------------------------------------
	// single indicator decode
	// ----------------------------------------
	function automatic sifs_pkg::sifs_drive_t decode(input int idx, input logic [3:0] code,
			input sifs_pkg::sifs_status_t s, input logic ph, input logic burst);
		sifs_pkg::sifs_drive_t d;
		logic lk;
		d = '0;
		lk = s.link_up;
		case (code)
			`SIFS_C_BASE: begin
				if (idx == 3) d.lit = lk && s.fiber; // [RULE_08]
				else if (idx == 1) d.lit = lk && !s.fiber; // [RULE_18]
				else d.lit = lk; // [RULE_12]
			end
			`SIFS_C_LINK_ACT: d.lit = lk && (!s.activity || ph); // [RULE_03]
			`SIFS_C_LINK_RX: begin
				if (idx == 3 || idx == 1) d.lit = lk && (!s.receive || ph); // [RULE_05]
				else if (idx == 0) d.lit = burst; // [RULE_21]
				else d.lit = 1'b0; // [RULE_15]
			end
			`SIFS_C_ACT_ON: d.lit = s.activity; // [RULE_04]
			`SIFS_C_ACT_BLINK: d.lit = s.activity && ph; // [RULE_04]
			`SIFS_C_5: begin
				if (idx == 1) d.lit = lk && (s.fiber || s.speed == `SIFS_SPD_100); // [RULE_19]
				else if (idx == 3) d.lit = 1'b0; // [RULE_11]
				else d.lit = s.transmit; // [RULE_13]
			end
			`SIFS_C_6: begin
				case (idx)
					3: d.lit = lk && (s.speed == `SIFS_SPD_10 || // [RULE_09]
						(s.speed == `SIFS_SPD_1000 && s.master));
					2: d.lit = lk && (s.speed == `SIFS_SPD_10 || s.speed == `SIFS_SPD_1000); // [RULE_14]
					1: d.lit = lk && (s.speed == `SIFS_SPD_100 || s.speed == `SIFS_SPD_1000); // [RULE_20]
					default: d.lit = lk && !s.fiber; // [RULE_22]
				endcase
			end
			`SIFS_C_7: begin
				case (idx)
					3: d.lit = s.full_duplex; // [RULE_10]
					2: d.lit = lk && s.speed == `SIFS_SPD_10; // [RULE_15]
					1: d.lit = lk && s.speed == `SIFS_SPD_100; // [RULE_20]
					default: d.lit = lk && s.speed == `SIFS_SPD_1000; // [RULE_22]
				endcase
			end
			`SIFS_C_FORCE_OFF: d.lit = 1'b0; // [RULE_06] [RULE_07]
			`SIFS_C_FORCE_ON: d.lit = 1'b1; // [RULE_06] [RULE_07]
			`SIFS_C_FORCE_HIZ: begin
				// the first indicator has no hi-z code; 1010 blinks there instead
				if (idx == 1) d.lit = ph; // [RULE_07]
				else d.hiz = 1'b1; // [RULE_06]
			end
			`SIFS_C_FORCE_BLINK: begin
				if (idx != 1) d.lit = ph; // [RULE_06] [RULE_24]
			end
			default: d = '0; // [RULE_07] [RULE_11] [RULE_25]
		endcase
		return d;
	endfunction

	// ----------------------------------------
	// dual indicator patterns: [1] lower index, [0] upper index
	// ----------------------------------------
	function automatic logic [1:0] dual(input logic hi_pair, input logic [3:0] code,
			input sifs_pkg::sifs_status_t s, input logic ph);
		logic [1:0] l;
		logic g;
		l = 2'h0;
		g = (s.speed == `SIFS_SPD_1000);
		case (code)
			`SIFS_C_DUAL_A: l = {s.link_up && g, s.link_up && !g};
			`SIFS_C_DUAL_B: l = {s.link_up, s.link_up && s.activity && ph};
			`SIFS_C_DUAL_C: begin
				if (hi_pair) l = {s.link_up && g, s.link_up && s.activity};
				else l = {s.link_up && (!s.activity || ph), s.link_up && s.full_duplex};
			end
			default: l = 2'h0; // [RULE_25]
		endcase
		return l;
	endfunction

	// ----------------------------------------
	// indicator selection
	// ----------------------------------------
	always_comb begin
		logic [1:0] dl;
		logic [1:0] dh;
		dl = dual(1'b0, code0, link_status, st_ff.blink_phase);
		dh = dual(1'b1, code2, link_status, st_ff.blink_phase);
		drv[0] = decode(0, code0, link_status, st_ff.blink_phase, burst_lit);
		drv[1] = decode(1, code1, link_status, st_ff.blink_phase, burst_lit);
		drv[2] = decode(2, code2, link_status, st_ff.blink_phase, burst_lit);
		drv[3] = decode(3, code3, link_status, st_ff.blink_phase, burst_lit);
		if (pair_lo) begin
			drv[0] = '{hiz: 1'b0, lit: dl[1]}; // [RULE_17]
			drv[1] = '{hiz: 1'b0, lit: dl[0]}; // [RULE_02]
		end
		if (pair_hi) begin
			drv[2] = '{hiz: 1'b0, lit: dh[1]}; // [RULE_16]
			drv[3] = '{hiz: 1'b0, lit: dh[0]}; // [RULE_01]
		end
	end

	// ----------------------------------------
	// state update and apb slave
	// ----------------------------------------
	always_comb begin
		nxt_st = st_ff;
		// one shared phase keeps every blinking indicator except the zeroth's speed burst in step
		if (blink_tick) nxt_st.blink_phase = ~st_ff.blink_phase; // [RULE_24]
		for (int i = 0; i < 4; i++) begin
			nxt_st.oe_n[i] = drv[i].hiz;
			// in hi-z the level is parked at off so a glitch never lights the lamp
			nxt_st.out[i] = (drv[i].lit && !drv[i].hiz) ? `SIFS_LIT_LEVEL : ~`SIFS_LIT_LEVEL; // [RULE_23]
		end
		case (st_ff.apb_st)
			sifs_pkg::SIFS_APB_IDLE: begin
				nxt_st.pready = 1'b0;
				nxt_st.pslverr = 1'b0;
				if (psel && penable) begin
					nxt_st.apb_st = sifs_pkg::SIFS_APB_ACK;
					nxt_st.pready = 1'b1;
					nxt_st.prdata = 32'h0000_0000;
					if (paddr == `SIFS_FUNC_SEL_OFF) begin
						if (pwrite) nxt_st.func_sel = pwdata[15:0];
						else nxt_st.prdata = {16'h0000, st_ff.func_sel};
					end else if (paddr == `SIFS_STATE_OFF && !pwrite) begin
						nxt_st.prdata = {23'h000000, st_ff.blink_phase, st_ff.oe_n, ~st_ff.out};
					end else begin
						// writes to read-only status and any access to an unmapped word are refused
						nxt_st.pslverr = 1'b1;
					end
				end
			end
			sifs_pkg::SIFS_APB_ACK: begin
				nxt_st.apb_st = sifs_pkg::SIFS_APB_IDLE;
				nxt_st.pready = 1'b0;
				nxt_st.pslverr = 1'b0;
			end
			default: begin
				nxt_st.apb_st = sifs_pkg::SIFS_APB_IDLE;
				nxt_st.pready = 1'b0;
				nxt_st.pslverr = 1'b0;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff.apb_st <= sifs_pkg::SIFS_APB_IDLE;
			st_ff.pready <= 1'b0;
			st_ff.pslverr <= 1'b0;
			st_ff.prdata <= 32'h0000_0000;
			st_ff.func_sel <= `SIFS_FUNC_SEL_RST;
			st_ff.blink_phase <= 1'b0;
			st_ff.out <= 4'hF;
			st_ff.oe_n <= 4'h0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign prdata = st_ff.prdata;
	assign pready = st_ff.pready;
	assign pslverr = st_ff.pslverr;
	assign indicator_out_0 = st_ff.out[0];
	assign indicator_out_1 = st_ff.out[1];
	assign indicator_out_2 = st_ff.out[2];
	assign indicator_out_3 = st_ff.out[3];
	assign indicator_oe_n_0 = st_ff.oe_n[0];
	assign indicator_oe_n_1 = st_ff.oe_n[1];
	assign indicator_oe_n_2 = st_ff.oe_n[2];
	assign indicator_oe_n_3 = st_ff.oe_n[3];

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_force_blink_held;
		(code0 == `SIFS_C_FORCE_BLINK && !pair_lo && blink_tick) ##1 (code0 == `SIFS_C_FORCE_BLINK);
	endsequence

	a_ignore_third: assert property (pair_hi && code3 == `SIFS_C_FORCE_ON && !link_status.link_up // [RULE_01]
		|=> indicator_out_3 == ~`SIFS_LIT_LEVEL)
		else $error("third indicator obeyed its field while paired");
	a_ignore_first: assert property (pair_lo && code1 == `SIFS_C_FORCE_ON && !link_status.link_up // [RULE_02]
		|=> indicator_out_1 == ~`SIFS_LIT_LEVEL)
		else $error("first indicator obeyed its field while paired");
	a_link_dark: assert property (code0 == `SIFS_C_LINK_ACT && !link_status.link_up // [RULE_03]
		|=> indicator_out_0 == ~`SIFS_LIT_LEVEL && !indicator_oe_n_0)
		else $error("link code lit without link");
	a_act_solid: assert property (code2 == `SIFS_C_ACT_ON && !pair_hi // [RULE_04]
		|=> indicator_out_2 == ~$past(link_status.activity))
		else $error("activity code does not follow activity");
	a_force_hiz: assert property (code0 == `SIFS_C_FORCE_HIZ // [RULE_06]
		|=> indicator_oe_n_0 && indicator_out_0 == ~`SIFS_LIT_LEVEL)
		else $error("hi-z code still drives the pin");
	a_first_blink: assert property (code1 == `SIFS_C_FORCE_HIZ && !pair_lo // [RULE_07]
		|=> !indicator_oe_n_1 && indicator_out_1 == ~$past(st_ff.blink_phase))
		else $error("first indicator code 1010 not blinking");
	a_full_dup: assert property (code3 == `SIFS_C_7 && !pair_hi // [RULE_10]
		|=> indicator_out_3 == ~$past(link_status.full_duplex))
		else $error("duplex code wrong");
	a_tx_on: assert property (code2 == `SIFS_C_5 && link_status.transmit // [RULE_13]
		|=> indicator_out_2 == `SIFS_LIT_LEVEL)
		else $error("transmit code dark while transmitting");
	a_copper_only: assert property (code1 == `SIFS_C_BASE && !pair_lo && link_status.fiber // [RULE_18]
		|=> indicator_out_1 == ~`SIFS_LIT_LEVEL)
		else $error("copper code lit on fiber");
	a_burst_none: assert property ((code0 == `SIFS_C_LINK_RX && !link_status.link_up) [*3] // [RULE_21]
		|=> indicator_out_0 == ~`SIFS_LIT_LEVEL)
		else $error("burst code blinks without link");
	a_blink_step: assert property (s_force_blink_held // [RULE_24]
		|=> indicator_out_0 != $past(indicator_out_0))
		else $error("forced blink missed a timer tick");
	a_reserved_dark: assert property (code0 == 4'hD // [RULE_25]
		|=> indicator_out_0 == ~`SIFS_LIT_LEVEL && indicator_out_1 == ~`SIFS_LIT_LEVEL)
		else $error("reserved dual code lit a lamp");
	a_apb_answer: assert property (psel && penable && !pready
		|=> pready ##1 !pready)
		else $error("apb answer not one cycle long");

endmodule
`default_nettype wire

// ===== src/sifs_map.svh
`ifndef SIFS_MAP_SVH
`define SIFS_MAP_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define SIFS_FUNC_SEL_OFF 8'h10
`define SIFS_STATE_OFF 8'h14
`define SIFS_FUNC_SEL_RST 16'h1777
`define SIFS_ADDR_W 8

// ----------------------------------------
// code field positions
// ----------------------------------------
`define SIFS_F3_LO 12
`define SIFS_F2_LO 8
`define SIFS_F1_LO 4
`define SIFS_F0_LO 0
`define SIFS_PAIR_CODE 2'h3

// ----------------------------------------
// function codes
// ----------------------------------------
`define SIFS_C_BASE 4'h0
`define SIFS_C_LINK_ACT 4'h1
`define SIFS_C_LINK_RX 4'h2
`define SIFS_C_ACT_ON 4'h3
`define SIFS_C_ACT_BLINK 4'h4
`define SIFS_C_5 4'h5
`define SIFS_C_6 4'h6
`define SIFS_C_7 4'h7
`define SIFS_C_FORCE_OFF 4'h8
`define SIFS_C_FORCE_ON 4'h9
`define SIFS_C_FORCE_HIZ 4'hA
`define SIFS_C_FORCE_BLINK 4'hB
`define SIFS_C_DUAL_A 4'hC
`define SIFS_C_DUAL_B 4'hE
`define SIFS_C_DUAL_C 4'hF

// ----------------------------------------
// speed codes and levels
// ----------------------------------------
`define SIFS_SPD_10 2'h0
`define SIFS_SPD_100 2'h1
`define SIFS_SPD_1000 2'h2
`define SIFS_LIT_LEVEL 1'b0
`define SIFS_BURST_PHASES 8

`endif

// ===== src/sifs_pkg.sv
`default_nettype none
package sifs_pkg;

	// ----------------------------------------
	// link status carrier
	// ----------------------------------------
	typedef struct packed {
		logic link_up;
		logic fiber;
		logic [1:0] speed;
		logic full_duplex;
		logic master;
		logic activity;
		logic transmit;
		logic receive;
	} sifs_status_t;

	typedef struct packed {
		logic hiz;
		logic lit;
	} sifs_drive_t;

	typedef enum logic [1:0] {
		SIFS_APB_IDLE = 2'h1,
		SIFS_APB_ACK = 2'h2
	} sifs_apb_st_t;

	typedef struct packed {
		sifs_apb_st_t apb_st;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic [15:0] func_sel;
		logic blink_phase;
		logic [3:0] out;
		logic [3:0] oe_n;
	} sifs_state_t;

	typedef struct packed {
		logic [2:0] phase;
		logic lit;
	} sifs_burst_state_t;

endpackage
`default_nettype wire

// ===== src/sifs_burst.sv
`timescale 1ns/100ps
`default_nettype none
`include "sifs_map.svh"

module sifs_burst #(
	parameter int PHASES = `SIFS_BURST_PHASES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic blink_tick,
	input wire logic [1:0] blink_count,
	output logic burst_lit
);

	// ----------------------------------------
	// checks
	// ----------------------------------------
	// three blinks need six slots plus a gap; counter is three bits wide
	if (PHASES < 7 || PHASES > 8) begin : g_bad_phases
		$error("sifs_burst: PHASES must be 7 or 8");
	end

	sifs_pkg::sifs_burst_state_t st_ff;
	sifs_pkg::sifs_burst_state_t nxt_st;

	// ----------------------------------------
	// burst sequencer
	// ----------------------------------------
	always_comb begin
		nxt_st = st_ff;
		if (blink_tick) begin
			if (st_ff.phase == 3'(PHASES - 1)) begin
				nxt_st.phase = 3'h0;
			end else begin
				nxt_st.phase = st_ff.phase + 3'h1;
			end
		end
		// even slots light, one slot per counted blink, then dark gap
		nxt_st.lit = ~st_ff.phase[0] && (st_ff.phase[2:1] < blink_count); // [RULE_21]
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign burst_lit = st_ff.lit;

endmodule
`default_nettype wire

// ===== tb/sifs_lamps.sv
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------
// board lamps: supply to pin through lamp
// ----------------------------------------
module sifs_lamps (
	input wire logic [3:0] pin_level,
	input wire logic [3:0] pin_oe_n,
	output logic [3:0] lamp_on
);
	// current flows only while the pin is driven low; a floating pin leaves it dark
	assign lamp_on = ~pin_oe_n & ~pin_level;
endmodule

`default_nettype wire

// ===== tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`include "sifs_map.svh"

module testbench;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	sifs_pkg::sifs_status_t link_status = '0;
	logic blink_tick = 1'b0;
	wire [3:0] out;
	wire [3:0] oe_n;
	logic [3:0] lamp_on;
	logic look = 1'b0;
	logic [33:0] q[$];
	logic [33:0] m_e;
	logic [31:0] rng = 32'hD3B3F209;
	int fails = 0;
	int total_checks = 0;
	int cycles = 0;

	always #5 pclk = ~pclk;

	sifs_top #(.BURST_PHASES(8)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link_status(link_status), .blink_tick(blink_tick),
		.indicator_out_0(out[0]), .indicator_out_1(out[1]), .indicator_out_2(out[2]),
		.indicator_out_3(out[3]), .indicator_oe_n_0(oe_n[0]), .indicator_oe_n_1(oe_n[1]),
		.indicator_oe_n_2(oe_n[2]), .indicator_oe_n_3(oe_n[3]));

	sifs_lamps i_lamps (.pin_level(out), .pin_oe_n(oe_n), .lamp_on(lamp_on));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] rnd();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng;
	endfunction

	// returns {hiz, lit}; blinking and paired codes are kept out of the random mix
	function automatic logic [1:0] ref_pin(input int i, input logic [3:0] c, input sifs_pkg::sifs_status_t s);
		logic l;
		logic [1:0] sp;
		l = s.link_up;
		sp = s.speed;
		case (c)
			4'h0: return {1'b0, l && (i == 3 ? s.fiber : i == 1 ? !s.fiber : 1'b1)};
			4'h1: return {1'b0, l};
			4'h2: return {1'b0, l && i[0]};
			4'h3: return {1'b0, s.activity};
			4'h5: return {1'b0, i == 3 ? 1'b0 : i == 1 ? l && (sp == 2'h1 || s.fiber) : s.transmit};
			4'h6: return {1'b0, l && (i == 3 ? sp == 2'h0 || sp == 2'h2 && s.master : i == 2 ?
				sp == 2'h0 || sp == 2'h2 : i == 1 ? sp == 2'h1 || sp == 2'h2 : !s.fiber)};
			4'h7: return {1'b0, i == 3 ? s.full_duplex : l && sp == (i == 2 ? 2'h0 : i == 1 ? 2'h1 : 2'h2)};
			4'h9: return 2'h1;
			4'hA: return {i != 1, 1'b0};
			default: return 2'h0;
		endcase
	endfunction

	function automatic bit bad(input int i, input logic [3:0] c, input sifs_pkg::sifs_status_t s);
		return c == 4'hB && i != 1 || c == 4'hA && i == 1 || (i == 2 || i == 0) && c[3:2] == 2'h3 ||
			i == 0 && c == 4'h2 || (c == 4'h1 || c == 4'h4) && s.activity || c == 4'h2 && s.receive;
	endfunction

	task automatic check(input logic [33:0] seen, input logic [33:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge pclk);
	endtask

	// exp is {data matters, pslverr, prdata}
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [33:0] exp);
		q.push_back(exp);
		@(posedge pclk) begin
			psel <= 1'b1;
			pwrite <= wr;
			paddr <= a;
			pwdata <= d;
		end
		@(posedge pclk) penable <= 1'b1;
		@(posedge pclk);
		// pready ends this wait; the hang guard catches a missing answer
		while (pready !== 1'b1) @(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic expect_lamps(input logic [7:0] e);
		q.push_back({26'h0, e});
		@(posedge pclk) look <= 1'b1;
		@(posedge pclk) look <= 1'b0;
	endtask

	task automatic tick();
		@(posedge pclk) blink_tick <= 1'b1;
		@(posedge pclk) blink_tick <= 1'b0;
	endtask

	task automatic set_codes(input logic [15:0] f, input logic [8:0] s);
		@(posedge pclk) link_status <= sifs_pkg::sifs_status_t'(s);
		apb(1'b1, `SIFS_FUNC_SEL_OFF, {16'h0, f}, 34'h0);
		idle(2);
	endtask

	task automatic blink_run(input logic [15:0] f, input logic [8:0] s);
		logic [3:0] prev;
		set_codes(f, s);
		repeat (3) begin
			idle(1);
			prev = lamp_on;
			check({30'h0, prev}, {30'h0, {4{prev[0]}}});
			tick();
			idle(3);
			expect_lamps({4'h0, ~prev});
		end
	endtask

	task end_sim;
		$display("checks %0d fails %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// ----------------------------------------
	// result watcher
	// ----------------------------------------
	always @(posedge pclk) begin
		if (look === 1'b1 && q.size() > 0) begin
			m_e = q.pop_front();
			check({26'h0, oe_n, lamp_on}, m_e);
		end else if (pready === 1'b1 && q.size() > 0) begin
			m_e = q.pop_front();
			check({m_e[33], pslverr, m_e[33] ? prdata : 32'h0}, m_e);
		end
	end

	// hang guard, well above the under a thousand cycles the run needs
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			end_sim();
		end
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		logic [31:0] r;
		logic [3:0] c[4];
		logic [1:0] p;
		logic [7:0] e;
		sifs_pkg::sifs_status_t st;
		int cnt;
		idle(8);
		presetn <= 1'b1;
		apb(1'b0, `SIFS_FUNC_SEL_OFF, 32'h0, {2'b10, 32'h1777});
		apb(1'b1, `SIFS_FUNC_SEL_OFF, 32'hFFFF_8998, 34'h0);
		apb(1'b0, `SIFS_FUNC_SEL_OFF, 32'h0, {2'b10, 32'h8998});
		apb(1'b1, `SIFS_STATE_OFF, 32'h0, {2'b01, 32'h0});
		apb(1'b0, 8'h20, 32'h0, {2'b11, 32'h0});
		// codes 8,9,9,8 without link: lamps one and two lit, nothing floating
		apb(1'b0, `SIFS_STATE_OFF, 32'h0, {2'b10, 32'h0000_0006});
		$display("test registers done");
		for (int k = 0; k < 60; k++) begin
			r = rnd();
			st = sifs_pkg::sifs_status_t'(r[8:0]);
			e = 8'h00;
			for (int i = 0; i < 4; i++) begin
				do begin
					r = rnd();
					c[i] = r[3:0];
				end while (bad(i, c[i], st));
				p = ref_pin(i, c[i], st);
				e[4 + i] = p[1];
				e[i] = p[0];
			end
			set_codes({c[3], c[2], c[1], c[0]}, st);
			expect_lamps(e);
		end
		$display("test random codes done");
		set_codes(16'h9D9D, 9'h1E0);
		expect_lamps(8'h00);
		set_codes(16'h9D9D, 9'h000);
		expect_lamps(8'h00);
		set_codes(16'h0E0E, 9'h100);
		expect_lamps(8'h05);
		set_codes(16'h0C0C, 9'h1C8);
		expect_lamps(8'h05);
		set_codes(16'h0C0C, 9'h198);
		expect_lamps(8'h0A);
		set_codes(16'h0F0F, 9'h198);
		expect_lamps(8'h03);
		$display("test pairing done");
		blink_run(16'hBBAB, 9'h100);
		blink_run(16'h1441, 9'h184);
		$display("test blinking done");
		for (int sp = 0; sp < 4; sp++) begin
			set_codes(16'h8882, {sp < 3, 1'b0, 2'(2 - sp), 5'h00});
			cnt = 0;
			repeat (8) begin
				tick();
				idle(3);
				cnt += lamp_on[0];
			end
			check(34'(cnt), 34'(sp < 3 ? 3 - sp : 0));
		end
		$display("test burst done");
		end_sim();
	end
endmodule

`default_nettype wire
